// ### logic/wdat_top.sv
`timescale 1ns/1ps
`include "wdat_consts.svh"

module wdat_top #(
    parameter int          BASE_CYCLES = `WDAT_BASE_CYCLES,
    parameter logic [15:0] SFR_LO      = 16'h0000,
    parameter logic [15:0] SFR_HI      = 16'h003F,
    parameter logic [15:0] RAM_LO      = 16'h0040,
    parameter logic [15:0] RAM_HI      = 16'h023F
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [3:0]            avs_byteenable,
    input  wire logic [31:0]           avs_writedata,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    input  wire wdat_pkg::wdat_fetch_t fetch,
    input  wire logic                  low_power,
    input  wire logic                  overflow_accept,
    input  wire logic                  fetch_trap_accept,
    output logic                       overflow_irq,
    output logic                       fetch_trap_irq,
    output logic                       sys_reset_req,
    output logic                       reset_pin_o,
    output logic                       reset_pin_oe_n
);
    import wdat_pkg::*;

    localparam logic [8:0] RST_LAST = 9'(`WDAT_RST_CYCLES - 1);

    // ************************************************************
    // reset image of the whole state
    // ************************************************************
    localparam wdat_state_t S_RST = '{
        phase:          WDAT_ST_RUN,
        ctl:            '{ram_trap_sel:        `WDAT_RST_ONE,
                          trap_action_sel:     `WDAT_RST_ONE,
                          supervision_on:      `WDAT_RST_ONE,
                          overflow_period_sel: `WDAT_RST_PERIOD,
                          overflow_action_sel: `WDAT_RST_ONE},
        active:         `WDAT_RST_ONE,
        ram_trap_eff:   `WDAT_RST_ONE,
        bincnt:         `WDAT_CNT_ZERO,
        overflow_irq:   `WDAT_RST_ZERO,
        fetch_trap_irq: `WDAT_RST_ZERO,
        pulse_cnt:      9'h000,
        ack:            `WDAT_RST_ZERO,
        rdata:          32'h0000_0000
    };

    wdat_state_t   s_reg;
    wdat_state_t   s_next;
    wdat_avs_req_t req;
    logic          req_any;
    logic          wr_go;
    logic          rd_go;
    logic          lane0;
    logic [7:0]    wbyte;
    logic          pre_run;
    logic          tick;
    logic          ovf;
    logic          in_sfr;
    logic          in_ram;
    logic          trap_hit;
    logic          do_reset;

    assign req = '{read:       avs_read,
                   write:      avs_write,
                   address:    avs_address,
                   byteenable: avs_byteenable,
                   writedata:  avs_writedata};

    // ************************************************************
    // bus handshake: one wait cycle, then the answer
    // ************************************************************
    assign req_any         = req.read | req.write;
    assign avs_waitrequest = req_any & ~s_reg.ack;
    assign wr_go           = req.write & s_reg.ack;
    assign rd_go           = req.read & ~s_reg.ack;
    assign lane0           = req.byteenable[0];
    assign wbyte           = req.writedata[7:0];

    // ************************************************************
    // divider, frozen in low-power modes
    // ************************************************************
    assign pre_run = ~low_power & (s_reg.phase == WDAT_ST_RUN);

    wdat_prescaler #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_pre (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .run        (pre_run),
        .period_sel (s_reg.ctl.overflow_period_sel),
        .tick       (tick)
    );

    // ************************************************************
    // overflow and fetch trap detection
    // ************************************************************
    // a step earned before a freeze still lands, so none is lost
    assign ovf = tick & s_reg.active & (s_reg.bincnt == `WDAT_CNT_TOP);
    assign in_sfr = (fetch.addr >= SFR_LO) && (fetch.addr <= SFR_HI);
    assign in_ram = (fetch.addr >= RAM_LO) && (fetch.addr <= RAM_HI);
    assign trap_hit = fetch.valid & (s_reg.phase == WDAT_ST_RUN)
                    & (in_sfr
                    | (in_ram & s_reg.ram_trap_eff));
    assign do_reset = (ovf & s_reg.ctl.overflow_action_sel)
                    | (trap_hit & s_reg.ctl.trap_action_sel);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_next     = s_reg;
        s_next.ack = req_any & ~s_reg.ack;

        // status read, control one reads as zero
        if (rd_go) begin
            unique case (req.address)
                `WDAT_OFS_STATUS: begin
                    s_next.rdata = {21'h0,
                                    s_reg.ctl.overflow_period_sel,
                                    s_reg.ctl.trap_action_sel,
                                    s_reg.ctl.overflow_action_sel,
                                    s_reg.phase == WDAT_ST_PULSE,
                                    s_reg.fetch_trap_irq,
                                    s_reg.overflow_irq,
                                    s_reg.bincnt,
                                    s_reg.ram_trap_eff,
                                    s_reg.active};
                end
                default: begin
                    s_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        unique case (s_reg.phase)
            WDAT_ST_RUN: begin
                // binary counter: 4 ticks to overflow
                if (tick & s_reg.active) begin
                    s_next.bincnt = s_reg.bincnt + 2'h1;
                end

                // control one write
                if (wr_go && lane0 && req.address == `WDAT_OFS_CTL_ONE) begin
                    s_next.ctl.ram_trap_sel =
                        wbyte[`WDAT_BIT_RAM_TRAP];
                    s_next.ctl.trap_action_sel =
                        wbyte[`WDAT_BIT_TRAP_ACT];
                    s_next.ctl.supervision_on =
                        wbyte[`WDAT_BIT_SUP_ON];
                    s_next.ctl.overflow_period_sel =
                        wbyte[`WDAT_BIT_PER_HI:`WDAT_BIT_PER_LO];
                    s_next.ctl.overflow_action_sel =
                        s_reg.ctl.overflow_action_sel
                        & wbyte[`WDAT_BIT_OVF_ACT];
                    if (wbyte[`WDAT_BIT_SUP_ON]) begin
                        s_next.active = 1'b1;
                    end
                end

                // code port write
                if (wr_go && lane0
                    && req.address == `WDAT_OFS_CODE_PORT) begin
                    unique case (wbyte)
                        `WDAT_CODE_CLEAR: begin
                            s_next.bincnt = `WDAT_CNT_ZERO;
                        end
                        `WDAT_CODE_DISABLE: begin
                            if (!s_reg.ctl.supervision_on) begin
                                s_next.active = 1'b0;
                            end
                        end
                        `WDAT_CODE_TRAP_ARM: begin
                            s_next.ram_trap_eff =
                                s_reg.ctl.ram_trap_sel;
                        end
                        default: begin
                        end
                    endcase
                end

                if (!s_next.active) begin
                    s_next.bincnt = `WDAT_CNT_ZERO;
                end

                // non-maskable requests, raised whatever is in service
                if (ovf & ~s_reg.ctl.overflow_action_sel) begin
                    s_next.overflow_irq = 1'b1;
                end else if (overflow_accept) begin
                    s_next.overflow_irq = 1'b0;
                end
                if (trap_hit & ~s_reg.ctl.trap_action_sel) begin
                    s_next.fetch_trap_irq = 1'b1;
                end else if (fetch_trap_accept) begin
                    s_next.fetch_trap_irq = 1'b0;
                end

                if (do_reset) begin
                    s_next.phase     = WDAT_ST_PULSE;
                    s_next.pulse_cnt = 9'h000;
                    s_next.bincnt    = `WDAT_CNT_ZERO;
                end
            end
            WDAT_ST_PULSE: begin
                s_next.pulse_cnt = s_reg.pulse_cnt + 9'h001;
                if (s_reg.pulse_cnt == RST_LAST) begin
                    // internal reinit, bus answer kept in flight
                    s_next       = S_RST;
                    s_next.ack   = req_any & ~s_reg.ack;
                    s_next.rdata = s_reg.rdata;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= S_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign avs_readdata   = s_reg.rdata;
    assign overflow_irq   = s_reg.overflow_irq;
    assign fetch_trap_irq = s_reg.fetch_trap_irq;
    assign sys_reset_req  = (s_reg.phase == WDAT_ST_PULSE);
    assign reset_pin_o    = 1'b0;
    assign reset_pin_oe_n = ~(s_reg.phase == WDAT_ST_PULSE);

endmodule : wdat_top

// ### logic/wdat_consts.svh
`ifndef WDAT_CONSTS_SVH
`define WDAT_CONSTS_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define WDAT_OFS_CTL_ONE    8'h34
`define WDAT_OFS_CODE_PORT  8'h38
`define WDAT_OFS_STATUS     8'h3C

// ************************************************************
// code port values
// ************************************************************
`define WDAT_CODE_CLEAR     8'h4E
`define WDAT_CODE_DISABLE   8'hB1
`define WDAT_CODE_TRAP_ARM  8'hD2

// ************************************************************
// control one bit positions
// ************************************************************
`define WDAT_BIT_OVF_ACT    0
`define WDAT_BIT_PER_LO     1
`define WDAT_BIT_PER_HI     2
`define WDAT_BIT_SUP_ON     3
`define WDAT_BIT_TRAP_ACT   4
`define WDAT_BIT_RAM_TRAP   5

// ************************************************************
// reset values and counter top
// ************************************************************
`define WDAT_RST_PERIOD     2'h0
`define WDAT_RST_ONE        1'h1
`define WDAT_RST_ZERO       1'h0
`define WDAT_CNT_ZERO       2'h0
`define WDAT_CNT_TOP        2'h3

// ************************************************************
// timing
// ************************************************************
`define WDAT_CLK_MHZ        250
`define WDAT_PERIOD11_US    32768
`define WDAT_PERIOD00_US    2097152
`define WDAT_BASE_CYCLES    (`WDAT_PERIOD11_US / 4 * `WDAT_CLK_MHZ)
`define WDAT_RST_TIME_NS    1500
`define WDAT_RST_CYCLES     (`WDAT_RST_TIME_NS * `WDAT_CLK_MHZ / 1000)
`define WDAT_TAP_BITS       6

`endif

// ### logic/wdat_pkg.sv
package wdat_pkg;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } wdat_fetch_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } wdat_avs_req_t;

    typedef enum logic [0:0] {
        WDAT_ST_RUN   = 1'b0,
        WDAT_ST_PULSE = 1'b1
    } wdat_phase_t;

    typedef struct packed {
        logic       ram_trap_sel;
        logic       trap_action_sel;
        logic       supervision_on;
        logic [1:0] overflow_period_sel;
        logic       overflow_action_sel;
    } wdat_ctl_t;

    typedef struct packed {
        wdat_phase_t phase;
        wdat_ctl_t   ctl;
        logic        active;
        logic        ram_trap_eff;
        logic [1:0]  bincnt;
        logic        overflow_irq;
        logic        fetch_trap_irq;
        logic [8:0]  pulse_cnt;
        logic        ack;
        logic [31:0] rdata;
    } wdat_state_t;

    typedef struct packed {
        logic [31:0] base_cnt;
        logic [5:0]  tap_cnt;
        logic        tick;
    } wdat_pre_t;

endpackage : wdat_pkg

// ### logic/wdat_prescaler.sv
`timescale 1ns/1ps
`include "wdat_consts.svh"

module wdat_prescaler #(
    parameter int BASE_CYCLES = `WDAT_BASE_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [1:0] period_sel,
    output logic            tick
);
    import wdat_pkg::*;

    wdat_pre_t s_reg;
    wdat_pre_t s_next;
    logic      base_hit;
    logic [5:0] mask;

    // ************************************************************
    // free divider, only the freeze input stops it
    // ************************************************************
    always_comb begin
        s_next   = s_reg;
        s_next.tick = 1'b0;
        base_hit = (s_reg.base_cnt == 32'(BASE_CYCLES - 1));
        // longer periods need more base ticks: 1, 4, 16 or 64
        mask = 6'(({6'h0, 6'h3F} >> (2 * period_sel)) & 12'h03F);
        if (run) begin
            if (base_hit) begin
                s_next.base_cnt = 32'h0;
                s_next.tap_cnt  = s_reg.tap_cnt + 6'h1;
                s_next.tick     = ((s_reg.tap_cnt & mask) == mask);
            end else begin
                s_next.base_cnt = s_reg.base_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

endmodule : wdat_prescaler

// ### verif/wdat_checker.sv
`timescale 1ns/1ps
// ************************************************************
// port checks: reset pin, traps, irq flags, bus reads
// ************************************************************
module wdat_checker #(
    parameter logic [15:0] SFR_LO = 16'h0000,
    parameter logic [15:0] SFR_HI = 16'h003F
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_waitrequest,
    input  wire logic [31:0]           avs_readdata,
    input  wire wdat_pkg::wdat_fetch_t fetch,
    input  wire logic                  fetch_trap_accept,
    input  wire logic                  overflow_irq,
    input  wire logic                  fetch_trap_irq,
    input  wire logic                  sys_reset_req,
    input  wire logic                  reset_pin_o,
    input  wire logic                  reset_pin_oe_n
);
    import wdat_pkg::*;
    localparam int PULSE = 375;
    logic [8:0] run_reg;
    logic       sfr_hit;
    assign sfr_hit = fetch.valid && fetch.addr >= SFR_LO
                     && fetch.addr <= SFR_HI;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_reg <= 9'h000;
        end else begin
            run_reg <= sys_reset_req ? run_reg + 9'h001 : 9'h000;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_pin_drive;
        reset_pin_oe_n == !sys_reset_req && reset_pin_o == 1'b0;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("reset pin drive wrong");
    property p_pulse_len;
        $fell(sys_reset_req) |-> run_reg == PULSE;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse length wrong");
    property p_sfr_trap;
        sfr_hit && !sys_reset_req |=> fetch_trap_irq || sys_reset_req;
    endproperty
    a_sfr_trap: assert property (p_sfr_trap)
        else $error("register area fetch not trapped");
    property p_trap_cause;
        $rose(fetch_trap_irq) |-> $past(fetch.valid);
    endproperty
    a_trap_cause: assert property (p_trap_cause)
        else $error("trap flag without fetch");
    property p_trap_hold;
        fetch_trap_irq && !fetch_trap_accept && !sys_reset_req
            |=> fetch_trap_irq;
    endproperty
    a_trap_hold: assert property (p_trap_hold)
        else $error("trap flag dropped unaccepted");
    property p_trap_clear;
        fetch_trap_accept && !fetch.valid |=> !fetch_trap_irq;
    endproperty
    a_trap_clear: assert property (p_trap_clear)
        else $error("trap flag kept after accept");
    property p_ctl_zero;
        avs_read && !avs_waitrequest && avs_address == 8'h34
            |-> avs_readdata == 32'h00000000;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero)
        else $error("control one read not zero");
    property p_reinit;
        $fell(sys_reset_req) |=> !overflow_irq && !fetch_trap_irq;
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("flags survive reset pulse");
    c_ovf: cover property ($rose(overflow_irq));
    c_trap: cover property ($rose(fetch_trap_irq));
    c_pulse: cover property ($fell(sys_reset_req));
endmodule : wdat_checker

bind wdat_top wdat_checker #(.SFR_LO(SFR_LO), .SFR_HI(SFR_HI)) chk_u (
    .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .fetch(fetch),
    .fetch_trap_accept(fetch_trap_accept), .overflow_irq(overflow_irq),
    .fetch_trap_irq(fetch_trap_irq), .sys_reset_req(sys_reset_req),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_n(reset_pin_oe_n));

// ### verif/wdat_cpu_model.sv
`timescale 1ns/1ps
// ************************************************************
// core side: instruction fetches and irq acceptance
// ************************************************************
module wdat_cpu_model (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             overflow_irq,
    input  wire logic             fetch_trap_irq,
    input  wire logic [3:0]       accept_delay,
    output wdat_pkg::wdat_fetch_t fetch,
    output logic                  overflow_accept,
    output logic                  fetch_trap_accept
);
    import wdat_pkg::*;
    logic [3:0] ovf_wait_reg;
    logic [3:0] trap_wait_reg;
    initial begin
        fetch = '0;
    end
    // idle address inverted so no stale value lingers
    task automatic fetch_at(input logic [15:0] a);
        fetch <= {1'b1, a};
        @(posedge ref_clk);
        fetch <= {1'b0, ~a};
    endtask : fetch_at
    // taken whatever the mask, stack assumed set up
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ovf_wait_reg <= 4'h0;
            trap_wait_reg <= 4'h0;
            overflow_accept <= 1'b0;
            fetch_trap_accept <= 1'b0;
        end else begin
            overflow_accept <= overflow_irq && !overflow_accept
                               && ovf_wait_reg == accept_delay;
            ovf_wait_reg <= (overflow_irq && !overflow_accept)
                            ? ovf_wait_reg + 4'h1 : 4'h0;
            fetch_trap_accept <= fetch_trap_irq && !fetch_trap_accept
                                 && trap_wait_reg == accept_delay;
            trap_wait_reg <= (fetch_trap_irq && !fetch_trap_accept)
                             ? trap_wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule : wdat_cpu_model

// ### verif/wdat_test.sv
`timescale 1ns/1ps
// ************************************************************
// bench: bus tasks, expectations, scenarios
// ************************************************************
module wdat_test;
    import wdat_pkg::*;
    localparam int BASE = 8;
    logic        ref_clk, rstn, avs_read, avs_write, low_power;
    logic        avs_waitrequest, overflow_irq, fetch_trap_irq;
    logic        sys_reset_req, reset_pin_o, reset_pin_oe_n;
    logic        overflow_accept, fetch_trap_accept;
    logic [7:0]  avs_address;
    logic [3:0]  avs_byteenable, acc_delay;
    logic [31:0] avs_writedata, avs_readdata, rd;
    wdat_fetch_t fetch;
    int          err_count, checks, cyc, n, m, tp, lp, lo, hi;

    wdat_top #(.BASE_CYCLES(BASE)) dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fetch(fetch), .low_power(low_power),
        .overflow_accept(overflow_accept),
        .fetch_trap_accept(fetch_trap_accept), .overflow_irq(overflow_irq),
        .fetch_trap_irq(fetch_trap_irq), .sys_reset_req(sys_reset_req),
        .reset_pin_o(reset_pin_o), .reset_pin_oe_n(reset_pin_oe_n));
    wdat_cpu_model cpu_u (
        .ref_clk(ref_clk), .rstn(rstn), .overflow_irq(overflow_irq),
        .fetch_trap_irq(fetch_trap_irq), .accept_delay(acc_delay),
        .fetch(fetch), .overflow_accept(overflow_accept),
        .fetch_trap_accept(fetch_trap_accept));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk_reg(input string s, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            err_count++;
        end
    endtask : chk_reg
    task automatic chk_bit(input string s, input logic e, g);
        checks++;
        if (g !== e) begin
            $display("ERROR %s expected %b seen %b", s, e, g);
            err_count++;
        end
    endtask : chk_bit
    task automatic bus(input logic w, input logic [7:0] a, d);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= w;
        avs_read <= !w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic wait_lv(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_lv
    task automatic trap(input logic [15:0] a, input logic e);
        cpu_u.fetch_at(a);
        @(posedge ref_clk);
        chk_bit("trap_irq", e, fetch_trap_irq);
        wait_lv(fetch_trap_irq, 1'b0, 40);
    endtask : trap
    function automatic logic [31:0] stat(input logic act, ram, oa, ta);
        return {21'h0, 2'h0, ta, oa, 5'h00, ram, act};
    endfunction : stat
    function automatic int plen(input int p);
        return BASE * 4 * (1 << (2 * (3 - p)));
    endfunction : plen

    initial begin
        {rstn, avs_read, avs_write, low_power} = 4'h0;
        {avs_address, avs_writedata, acc_delay} = '0;
        avs_byteenable = 4'hF;
        {err_count, checks, cyc} = '0;
        n = $urandom(85);
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, 8'h3C, 8'h00);
        chk_reg("status_reset", stat(1, 1, 1, 1), rd);
        bus(1'b0, 8'h34, 8'h00);
        chk_reg("ctl_read", 32'h0, rd);
        bus(1'b1, 8'h10, 8'hFF);
        bus(1'b0, 8'h10, 8'h00);
        chk_reg("unmapped", 32'h0, rd);
        $display("test reset done");
        for (int p = 3; p >= 0; p--) begin
            acc_delay <= 4'($urandom_range(15));
            bus(1'b1, 8'h34, {5'b00001, 2'(p), 1'b0});
            lp = (p == 1) ? 40 : 0;
            tp = plen(p);
            bus(1'b1, 8'h38, 8'h4E);
            if (p == 1) begin
                low_power <= 1'b1;
                repeat (40) @(posedge ref_clk);
                low_power <= 1'b0;
            end
            wait_lv(overflow_irq, 1'b1, 2 * tp);
            m = lp + n;
            lo = 3 * tp / 4 + lp - 2;
            hi = tp + lp + 4;
            chk_bit("ovf_early", 1'b1, m >= lo);
            chk_bit("ovf_late", 1'b1, m <= hi);
            wait_lv(overflow_irq, 1'b0, 20);
            chk_bit("ovf_accept", 1'b1, n < 20);
        end
        bus(1'b1, 8'h34, 8'h0F);
        bus(1'b0, 8'h3C, 8'h00);
        chk_bit("ovf_sticky", 1'b0, rd[7]);
        $display("test periods done");
        acc_delay <= 4'h6;
        trap(16'h0040 + 16'($urandom_range(511)), 1'b1);
        bus(1'b1, 8'h38, 8'hD2);
        bus(1'b0, 8'h3C, 8'h00);
        chk_bit("ram_eff", 1'b0, rd[1]);
        trap(16'h0040 + 16'($urandom_range(511)), 1'b0);
        for (int i = 0; i < 3; i++) begin
            trap(16'($urandom_range(63)), 1'b1);
        end
        $display("test traps done");
        bus(1'b1, 8'h38, 8'hB1);
        bus(1'b0, 8'h3C, 8'h00);
        chk_bit("b1_refused", 1'b1, rd[0]);
        bus(1'b1, 8'h38, 8'h4E);
        bus(1'b1, 8'h34, 8'h06);
        bus(1'b1, 8'h38, 8'hB1);
        repeat (3 * plen(3)) @(posedge ref_clk);
        bus(1'b0, 8'h3C, 8'h00);
        chk_reg("disabled", 32'h0, rd & 32'h0000001D);
        $display("test disable done");
        bus(1'b1, 8'h34, 8'h16);
        cpu_u.fetch_at(16'($urandom_range(63)));
        wait_lv(sys_reset_req, 1'b1, 4);
        chk_bit("trap_reset", 1'b1, sys_reset_req);
        wait_lv(sys_reset_req, 1'b0, 400);
        chk_bit("pulse_len", 1'b1, n >= 370 && n <= 376);
        bus(1'b0, 8'h3C, 8'h00);
        chk_reg("reinit", stat(1, 1, 1, 1), rd);
        bus(1'b1, 8'h34, 8'h3F);
        wait_lv(sys_reset_req, 1'b1, 2 * plen(3) + 8);
        chk_bit("ovf_reset", 1'b1, sys_reset_req);
        wait_lv(sys_reset_req, 1'b0, 400);
        $display("test resets done");
        results();
    end
endmodule : wdat_test
